// ===== hdl/wavegen_consts.vh
`ifndef WAVEGEN_CONSTS_VH
`define WAVEGEN_CONSTS_VH
// Waveform select codes
`define WAVE_TRIANGLE      3'h0
`define WAVE_SAW_UP        3'h1
`define WAVE_SAW_DOWN      3'h2
`define WAVE_SINE          3'h4
// Sine table length and phase spacing
`define SINE_POINTS        5'h18
`define SINE_LAST          5'h17
`define SINE_PHASE_STEP    5'h06
`define SINE_MID           12'h800
// Action trigger keys
`define RESET_KEY          4'ha
`define UNLOCK_KEY         4'h5
// Voltage shutdown encodings
`define VOUT_ON            2'h0
`define VOUT_PD_10K        2'h1
`define VOUT_PD_100K       2'h2
`define VOUT_HIZ           2'h3
// Factory reset values
`define VOUT_SHUTDOWN_RST  2'h3
`define IOUT_SHUTDOWN_RST  1'h1
`define LIMIT_LOW_RST      12'h000
`define LIMIT_HIGH_RST     12'hfff
// CRC-16-CCITT
`define CRC_POLY           16'h1021
`define CRC_INIT           16'hffff
// Boot-up delay in cycles
`define BOOT_DELAY_CYCLES  16'h0100
`endif

// ===== hdl/wave_channel.v
`timescale 1ns/1ps
`default_nettype none
`include "wavegen_consts.vh"
module wave_channel (
  input  wire        clock,
  input  wire        reset_n,
  input  wire        run,
  input  wire        step_tick,
  input  wire [2:0]  waveform_select,
  input  wire [1:0]  sine_phase,
  input  wire [11:0] limit_low,
  input  wire [11:0] limit_high,
  input  wire [11:0] step_size,
  output reg  [11:0] code
);
  reg [4:0] sine_index;
  reg       tri_down;

  // Fixed 24-point sine table
  function [11:0] sine_lut;
    input [4:0] i;
    begin
      case (i)
        5'h00: sine_lut = 12'h800;
        5'h01: sine_lut = 12'h9a8;
        5'h02: sine_lut = 12'hb33;
        5'h03: sine_lut = 12'hc87;
        5'h04: sine_lut = 12'hd8b;
        5'h05: sine_lut = 12'he2f;
        5'h06: sine_lut = 12'he66;
        5'h07: sine_lut = 12'he2f;
        5'h08: sine_lut = 12'hd8b;
        5'h09: sine_lut = 12'hc87;
        5'h0a: sine_lut = 12'hb33;
        5'h0b: sine_lut = 12'h9a8;
        5'h0c: sine_lut = 12'h800;
        5'h0d: sine_lut = 12'h658;
        5'h0e: sine_lut = 12'h4cd;
        5'h0f: sine_lut = 12'h379;
        5'h10: sine_lut = 12'h275;
        5'h11: sine_lut = 12'h1d1;
        5'h12: sine_lut = 12'h19a;
        5'h13: sine_lut = 12'h1d1;
        5'h14: sine_lut = 12'h275;
        5'h15: sine_lut = 12'h379;
        5'h16: sine_lut = 12'h4cd;
        5'h17: sine_lut = 12'h658;
        default: sine_lut = `SINE_MID;
      endcase
    end
  endfunction

  // 13-bit sums avoid wrap past full scale
  wire [12:0] up_sum = {1'b0, code} + {1'b0, step_size};
  wire [12:0] dn_dif = {1'b0, code} - {1'b0, step_size};
  wire        up_hit = (up_sum >= {1'b0, limit_high});
  wire        dn_hit = dn_dif[12] || (dn_dif <= {1'b0, limit_low});
  wire [4:0]  start_index = sine_phase * `SINE_PHASE_STEP;

  // One step per step period; idle holds the lower limit, the upper limit for falling saw, or the sine phase start
  always @(posedge clock) begin
    if (!reset_n) begin
      code       <= `LIMIT_LOW_RST;
      sine_index <= 5'h00;
      tri_down   <= 1'b0;
    end else if (!run) begin
      sine_index <= start_index;
      tri_down   <= 1'b0;
      code       <= (waveform_select == `WAVE_SINE) ? sine_lut(start_index) :
                    (waveform_select == `WAVE_SAW_DOWN) ? limit_high : limit_low;
    end else if (step_tick) begin
      case (waveform_select)
        `WAVE_SAW_UP: begin
          // Clamp at the top, then restart from the bottom; a code left
          // above a new upper limit is clamped first, not wrapped
          if (code == limit_high)
            code <= limit_low;
          else if (up_hit)
            code <= limit_high;
          else
            code <= up_sum[11:0];
        end
        `WAVE_SAW_DOWN: begin
          if (code == limit_low)
            code <= limit_high;
          else if (dn_hit)
            code <= limit_low;
          else
            code <= dn_dif[11:0];
        end
        `WAVE_SINE: begin
          // One table point per step period, 24 per cycle
          sine_index <= (sine_index == `SINE_LAST) ? 5'h00 : sine_index + 5'h01;
          code       <= sine_lut(sine_index);
        end
        `WAVE_TRIANGLE: begin
          if (!tri_down) begin
            if (up_hit) begin
              code     <= limit_high;
              tri_down <= 1'b1;
            end else
              code <= up_sum[11:0];
          end else begin
            if (dn_hit) begin
              code     <= limit_low;
              tri_down <= 1'b0;
            end else
              code <= dn_dif[11:0];
          end
        end
        default: code <= code; // Unused select codes hold the output
      endcase
    end
  end
endmodule // wave_channel
`default_nettype wire

// ===== hdl/dac_wavegen_reset_powerdown_ctrl.v
// What this block does
// - Codes 001/010 give rising/falling sawtooth.
// - Sawtooth swings between lower and upper limit.
// - Advance step size once per step period.
// - Sine: 24 points, one per step.
// - Code 100 selects sine generation.
// - Sine samples from fixed 12-bit table.
// - Four selectable sine starting phases.
// - Power-on reloads store; wait boot delay.
// - Reset key 1010 reruns boot; waveform settings kept, run bits cleared.
// - Reset pin falling edge boots; rising ignored.
// - Lock bit rejects writes; reset still works.
// - Key 0101 bypasses the write lock.
// - CRC-16-CCITT checks stored data at boot.
// - Two check flags, set only at boot.
// - User check failure loads factory values.
// - Flags clear only by reset/power cycle.
// - Outputs off while booting; reference off after power-up.
// - Voltage shutdown field: on/10k/100k/high-Z.
// - Current shutdown bit: 0 on, 1 high-Z.
// - Shutdown bits mappable to general-purpose pin.
// - Power-up channel state follows stored values.
// - Code 000 selects triangle, same settings.
`timescale 1ns/1ps
`default_nettype none
`include "wavegen_consts.vh"
module dac_wavegen_reset_powerdown_ctrl (
  input  wire        clock,
  input  wire        reset_n,
  // Host register write port (one channel selected per write)
  input  wire        write_strobe,
  input  wire [1:0]  write_channel,
  input  wire [2:0]  write_waveform_select,
  input  wire [1:0]  write_sine_phase,
  input  wire [11:0] write_limit_low,
  input  wire [11:0] write_limit_high,
  input  wire [11:0] write_step_size,
  input  wire [15:0] write_step_period,
  input  wire        write_run,
  input  wire [1:0]  write_voltage_out_shutdown,
  input  wire        write_current_out_shutdown,
  input  wire        write_gpio_sleep_map,
  input  wire        common_write_strobe,
  input  wire        write_write_lock,
  input  wire        write_reference_enable,
  input  wire        action_strobe,
  input  wire [3:0]  action_reset_field,
  input  wire [3:0]  action_lock_bypass_key,
  // General-purpose pin
  input  wire        gpio_in,
  input  wire        gpio_is_reset,
  input  wire        gpio_is_sleep,
  // Nonvolatile store image, read at boot
  input  wire [15:0] store_word,
  input  wire [15:0] store_user_crc,
  input  wire [15:0] store_factory_word,
  input  wire [15:0] store_factory_crc,
  input  wire [7:0]  store_powerup_shutdown,
  // Status and outputs
  output wire        booting,
  output wire        host_ready,
  output wire        write_rejected,
  output reg         write_lock,
  output reg         lock_bypassed,
  output reg         reference_enable,
  output reg         user_store_check_fail,
  output reg         factory_store_check_fail,
  output reg  [47:0] channel_code,
  output wire [7:0]  voltage_out_enable,
  output wire [3:0]  vout_pulldown_10k,
  output wire [3:0]  vout_pulldown_100k,
  output wire [3:0]  current_out_enable
);
  localparam ST_BOOT  = 3'b001;
  localparam ST_CHECK = 3'b010;
  localparam ST_RUN   = 3'b100;

  reg  [2:0]  state;
  reg  [15:0] boot_count;
  reg  [2:0]  wave_sel   [0:3];
  reg  [1:0]  phase_sel  [0:3];
  reg  [11:0] lim_low    [0:3];
  reg  [11:0] lim_high   [0:3];
  reg  [11:0] step_size  [0:3];
  reg  [15:0] step_per   [0:3];
  reg  [15:0] step_cnt   [0:3];
  reg  [3:0]  run_en;
  reg  [1:0]  vout_sd    [0:3];
  reg  [3:0]  iout_sd;
  reg  [3:0]  sleep_map;
  reg         gpio_prev;
  wire [47:0] codes;
  integer     i;
  integer     j;

  // Bitwise CRC-16-CCITT over one 16-bit word
  function [15:0] crc16_word;
    input [15:0] seed;
    input [15:0] data;
    integer k;
    reg [15:0] c;
    begin
      c = seed;
      for (k = 15; k >= 0; k = k - 1)
        c = (c[15] ^ data[k]) ? ((c << 1) ^ `CRC_POLY) : (c << 1);
      crc16_word = c;
    end
  endfunction

  wire user_bad    = crc16_word(`CRC_INIT, store_word) != store_user_crc;
  wire factory_bad = crc16_word(`CRC_INIT, store_factory_word) != store_factory_crc;
  wire pin_reset   = gpio_is_reset && gpio_prev && !gpio_in;
  wire soft_reset  = action_strobe && (action_reset_field == `RESET_KEY);
  wire reboot      = soft_reset || pin_reset;
  wire bypass_now  = action_strobe && (action_lock_bypass_key == `UNLOCK_KEY);
  wire locked      = write_lock && !lock_bypassed && !bypass_now;
  wire any_write   = write_strobe || common_write_strobe;

  assign booting        = (state != ST_RUN);
  assign host_ready     = (state == ST_RUN);
  assign write_rejected = any_write && (booting || locked);

  // Previous pin level for the falling edge
  always @(posedge clock) begin
    if (!reset_n)
      gpio_prev <= 1'b1;
    else
      gpio_prev <= gpio_in;
  end

  // Boot sequencer: delay, check, load, then accept writes
  always @(posedge clock) begin
    if (!reset_n) begin
      state                    <= ST_BOOT;
      boot_count               <= 16'h0000;
      user_store_check_fail    <= 1'b0;
      factory_store_check_fail <= 1'b0;
      write_lock               <= 1'b0;
      lock_bypassed            <= 1'b0;
      reference_enable         <= 1'b0;
      run_en                   <= 4'h0;
      iout_sd                  <= 4'hf;
      sleep_map                <= 4'h0;
      for (i = 0; i < 4; i = i + 1) begin
        wave_sel[i]  <= `WAVE_TRIANGLE;
        phase_sel[i] <= 2'h0;
        lim_low[i]   <= `LIMIT_LOW_RST;
        lim_high[i]  <= `LIMIT_HIGH_RST;
        step_size[i] <= 12'h001;
        step_per[i]  <= 16'h0000;
        vout_sd[i]   <= `VOUT_SHUTDOWN_RST;
      end
    end else if (reboot) begin
      // Software or pin reset reruns the boot; waveform settings are kept, run bits are cleared
      state                    <= ST_BOOT;
      boot_count               <= 16'h0000;
      user_store_check_fail    <= 1'b0;
      factory_store_check_fail <= 1'b0;
      write_lock               <= 1'b0;
      lock_bypassed            <= 1'b0;
      reference_enable         <= 1'b0;
      run_en                   <= 4'h0;
    end else begin
      case (state)
        ST_BOOT: begin
          boot_count <= boot_count + 16'h0001;
          if (boot_count == `BOOT_DELAY_CYCLES - 16'h0001)
            state <= ST_CHECK;
        end
        ST_CHECK: begin
          // Flags can only rise here, during boot
          user_store_check_fail    <= user_bad;
          factory_store_check_fail <= factory_bad;
          for (i = 0; i < 4; i = i + 1) begin
            if (user_bad || factory_bad) begin
              vout_sd[i] <= `VOUT_SHUTDOWN_RST;
              iout_sd[i] <= `IOUT_SHUTDOWN_RST;
            end else begin
              vout_sd[i] <= store_powerup_shutdown[2*i +: 2];
              iout_sd[i] <= store_powerup_shutdown[i];
            end
          end
          state <= ST_RUN;
        end
        ST_RUN: begin
          if (bypass_now)
            lock_bypassed <= 1'b1;
          if (common_write_strobe && !locked) begin
            write_lock       <= write_write_lock;
            reference_enable <= write_reference_enable;
            // A bypass key in the same cycle wins over the relock
            if (write_write_lock && !bypass_now)
              lock_bypassed <= 1'b0;
          end
          // Registers stay writable after a check failure
          if (write_strobe && !locked) begin
            wave_sel[write_channel]  <= write_waveform_select;
            phase_sel[write_channel] <= write_sine_phase;
            lim_low[write_channel]   <= write_limit_low;
            lim_high[write_channel]  <= write_limit_high;
            step_size[write_channel] <= write_step_size;
            step_per[write_channel]  <= write_step_period;
            run_en[write_channel]    <= write_run;
            vout_sd[write_channel]   <= write_voltage_out_shutdown;
            iout_sd[write_channel]   <= write_current_out_shutdown;
            sleep_map[write_channel] <= write_gpio_sleep_map;
          end
        end
        default: state <= ST_BOOT;
      endcase
    end
  end

  // Step-period dividers: one-cycle tick per period per channel
  always @(posedge clock) begin
    if (!reset_n) begin
      for (j = 0; j < 4; j = j + 1)
        step_cnt[j] <= 16'h0000;
    end else begin
      for (j = 0; j < 4; j = j + 1)
        if (!run_en[j] || step_cnt[j] >= step_per[j])
          step_cnt[j] <= 16'h0000;
        else
          step_cnt[j] <= step_cnt[j] + 16'h0001;
    end
  end

  // Output codes registered; cleared while booting
  always @(posedge clock) begin
    if (!reset_n)
      channel_code <= 48'h000000000000;
    else
      channel_code <= booting ? 48'h000000000000 : codes;
  end

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : ch
      wire tick  = run_en[g] && (step_cnt[g] >= step_per[g]);
      // Sleep via the pin forces the channel to high impedance
      wire sleep = gpio_is_sleep && sleep_map[g] && !gpio_in;
      wire [1:0] vsd = sleep ? `VOUT_HIZ : vout_sd[g];
      wave_channel u_wave (
        .clock           (clock),
        .reset_n         (reset_n),
        .run             (run_en[g] && !booting),
        .step_tick       (tick),
        .waveform_select (wave_sel[g]),
        .sine_phase      (phase_sel[g]),
        .limit_low       (lim_low[g]),
        .limit_high      (lim_high[g]),
        .step_size       (step_size[g]),
        .code            (codes[12*g +: 12])
      );
      // Shutdown decode
      assign voltage_out_enable[g]     = !booting && (vsd == `VOUT_ON);
      assign voltage_out_enable[g + 4] = 1'b0;
      assign vout_pulldown_10k[g]      = (vsd == `VOUT_PD_10K);
      assign vout_pulldown_100k[g]     = (vsd == `VOUT_PD_100K);
      assign current_out_enable[g]     = !booting && !sleep && !iout_sd[g];
    end
  endgenerate
endmodule // dac_wavegen_reset_powerdown_ctrl
`default_nettype wire

// ===== dv/ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ctrl_monitor (
  input wire logic       clock,
  input wire logic       reset_n,
  input wire logic       write_strobe,
  input wire logic       common_write_strobe,
  input wire logic       action_strobe,
  input wire logic [3:0] action_reset_field,
  input wire logic [3:0] action_lock_bypass_key,
  input wire logic       gpio_in,
  input wire logic       gpio_is_reset,
  input wire logic       booting,
  input wire logic       host_ready,
  input wire logic       write_rejected,
  input wire logic       write_lock,
  input wire logic       lock_bypassed,
  input wire logic       user_store_check_fail,
  input wire logic       factory_store_check_fail,
  input wire logic [7:0] voltage_out_enable,
  input wire logic [3:0] vout_pulldown_10k,
  input wire logic [3:0] vout_pulldown_100k,
  input wire logic [3:0] current_out_enable
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Reboot causes, each a step that must start the boot
  sequence soft_key;
    action_strobe && action_reset_field == 4'ha && host_ready;
  endsequence
  sequence pin_fall;
    gpio_is_reset && $fell(gpio_in) && host_ready;
  endsequence
  off_after_reset_a: assert property (disable iff (1'b0) !reset_n |=>
    voltage_out_enable == 8'h00 && current_out_enable == 4'h0) else $error("outputs on in reset");
  boot_wait_a: assert property ($rose(reset_n) |-> booting [*8])
    else $error("boot delay too short");
  // Edges spent booting; power-on and a reboot both show 257
  int boot_len;
  always @(posedge clock) begin
    if (!reset_n || !booting) boot_len <= 0;
    else if (boot_len < 1000) boot_len <= boot_len + 1;
  end
  boot_length_a: assert property ($rose(host_ready) |-> boot_len >= 256 && boot_len <= 257)
    else $error("ready after wrong boot length");
  boot_reject_a: assert property (write_strobe && booting |-> write_rejected)
    else $error("write taken while booting");
  lock_reject_a: assert property (write_strobe && host_ready && write_lock &&
    !lock_bypassed && !(action_strobe && action_lock_bypass_key == 4'h5) |-> write_rejected)
    else $error("locked write not refused");
  soft_reset_a: assert property (soft_key |=> booting [*4])
    else $error("reset key did not reboot");
  pin_reset_a: assert property (pin_fall |-> ##[1:2] booting)
    else $error("pin fall did not reboot");
  unlock_a: assert property (action_strobe && action_lock_bypass_key == 4'h5 &&
    action_reset_field != 4'ha && !common_write_strobe && host_ready |=> lock_bypassed)
    else $error("unlock key ignored");
  flag_boot_a: assert property ($rose(user_store_check_fail) ||
    $rose(factory_store_check_fail) |-> $past(booting)) else $error("flag set outside boot");
  flag_hold_a: assert property (host_ready && $past(host_ready) |->
    $stable({user_store_check_fail, factory_store_check_fail})) else $error("flag changed");
  pulldown_excl_a: assert property (((vout_pulldown_10k & vout_pulldown_100k) |
    ((vout_pulldown_10k | vout_pulldown_100k) & voltage_out_enable[3:0])) == 4'h0)
    else $error("shutdown decode overlaps");
endmodule // ctrl_monitor
bind dac_wavegen_reset_powerdown_ctrl ctrl_monitor u_monitor (.*);
`default_nettype wire

// ===== dv/nv_store.sv
`timescale 1ns/1ps
`default_nettype none
module nv_store (
  input  wire logic        bad_user,
  input  wire logic        bad_factory,
  output logic      [15:0] store_word,
  output logic      [15:0] store_user_crc,
  output logic      [15:0] store_factory_word,
  output logic      [15:0] store_factory_crc,
  output logic      [7:0]  store_powerup_shutdown
);
  // Bit-serial CRC, msb first; a corrupt image flips the low bit of the code
  function automatic logic [15:0] crc16(input logic [15:0] d);
    logic [15:0] c;
    c = 16'hffff;
    for (int i = 15; i >= 0; i--) begin
      c = (c[15] ^ d[i]) ? ({c[14:0], 1'b0} ^ 16'h1021) : {c[14:0], 1'b0};
    end
    return c;
  endfunction
  // Stored image; data words are arbitrary
  assign store_word = 16'h3c5a;
  assign store_user_crc = crc16(16'h3c5a) ^ {15'h0000, bad_user};
  assign store_factory_word = 16'h9e21;
  assign store_factory_crc = crc16(16'h9e21) ^ {15'h0000, bad_factory};
  assign store_powerup_shutdown = 8'he4;
endmodule // nv_store
`default_nettype wire

// ===== dv/test_dac_wavegen_reset_powerdown_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_dac_wavegen_reset_powerdown_ctrl;
  logic clock = 1'b0, reset_n = 1'b0, write_strobe = 1'b0, write_run = 1'b0;
  logic common_write_strobe = 1'b0, write_write_lock = 1'b0, write_reference_enable = 1'b0;
  logic action_strobe = 1'b0, write_current_out_shutdown = 1'b1, write_gpio_sleep_map = 1'b0;
  logic gpio_in = 1'b1, gpio_is_reset = 1'b0, gpio_is_sleep = 1'b0;
  logic bad_user = 1'b0, bad_factory = 1'b0;
  logic [1:0]  write_channel = 2'h0, write_sine_phase = 2'h0, write_voltage_out_shutdown = 2'h3;
  logic [2:0]  write_waveform_select = 3'h0;
  logic [3:0]  action_reset_field = 4'h0, action_lock_bypass_key = 4'h0;
  logic [11:0] write_limit_low = 12'h000, write_limit_high = 12'h000, write_step_size = 12'h001;
  logic [15:0] write_step_period = 16'h0000;
  wire  [15:0] store_word, store_user_crc, store_factory_word, store_factory_crc;
  wire  [7:0]  store_powerup_shutdown, voltage_out_enable;
  wire  [3:0]  vout_pulldown_10k, vout_pulldown_100k, current_out_enable;
  wire  [47:0] channel_code;
  wire booting, host_ready, write_rejected, write_lock, lock_bypassed, reference_enable;
  wire user_store_check_fail, factory_store_check_fail;
  int bad_count = 0;
  int n_compared = 0;
  localparam logic [11:0] SINE_HALF [12] = '{12'h800, 12'h9a8, 12'hb33, 12'hc87, 12'hd8b,
    12'he2f, 12'he66, 12'he2f, 12'hd8b, 12'hc87, 12'hb33, 12'h9a8};

  dac_wavegen_reset_powerdown_ctrl DUT (.*);
  nv_store u_store (.bad_user(bad_user), .bad_factory(bad_factory), .store_word(store_word),
    .store_user_crc(store_user_crc), .store_factory_word(store_factory_word),
    .store_factory_crc(store_factory_crc), .store_powerup_shutdown(store_powerup_shutdown));

  always #20 clock = ~clock;

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Second half of the table mirrors the first about midscale
  function automatic logic [11:0] sine_pt(input int i);
    return (i < 12) ? SINE_HALF[i] : 12'h000 - SINE_HALF[i - 12];
  endfunction
  task automatic wr;
    @(negedge clock) write_strobe = 1'b1;
    @(negedge clock) write_strobe = 1'b0;
  endtask
  task automatic com(input logic lock);
    write_write_lock = lock;
    @(negedge clock) common_write_strobe = 1'b1;
    @(negedge clock) common_write_strobe = 1'b0;
  endtask
  task automatic act(input logic [3:0] rst, input logic [3:0] key);
    action_reset_field = rst;
    action_lock_bypass_key = key;
    @(negedge clock) action_strobe = 1'b1;
    @(negedge clock) action_strobe = 1'b0;
  endtask
  task automatic wait_ready;
    for (int n = 0; n < 600 && host_ready !== 1'b1; n++) @(negedge clock);
    chk(host_ready, 1'b1);
  endtask
  task automatic pwr_default; // Store asks ch0 on, ch1 10k, ch2 100k, ch3 off
    chk({voltage_out_enable, vout_pulldown_10k, vout_pulldown_100k, current_out_enable},
      {8'h01, 4'h2, 4'h4, 4'hb});
  endtask
  task automatic set_ch(input logic [1:0] ch, input logic [1:0] vsd, input logic isd);
    write_channel = ch;
    write_voltage_out_shutdown = vsd;
    write_current_out_shutdown = isd;
  endtask

  task automatic t_boot;
    repeat (16) @(negedge clock);
    chk({voltage_out_enable, current_out_enable, reference_enable, host_ready}, 14'h0);
    reset_n = 1'b1;
    wr(); // Refused while the boot delay runs
    wait_ready();
    chk({user_store_check_fail, factory_store_check_fail}, 2'b00);
    pwr_default();
  endtask
  task automatic t_saw(input logic [2:0] sel, input logic [12:0] lo, hi, st, input int per);
    logic [12:0] v, e;
    int gap;
    logic seen;
    logic up;
    set_ch(2'h0, 2'h0, 1'b0);
    {write_waveform_select, write_limit_low, write_limit_high} = {sel, lo[11:0], hi[11:0]};
    {write_step_size, write_step_period, write_run} = {st[11:0], per[15:0], 1'b1};
    wr();
    repeat (3) @(negedge clock);
    v = {1'b0, channel_code[11:0]};
    gap = 0;
    seen = 1'b0;
    repeat (48) begin
      @(negedge clock);
      gap++;
      if (channel_code[11:0] !== v[11:0]) begin
        // Triangle direction is learnt from the first step seen
        if (!seen) up = channel_code[11:0] > v[11:0];
        if (sel == 3'h1) e = (v == hi) ? lo : ((v + st > hi) ? hi : v + st);
        else if (sel == 3'h2) e = (v == lo) ? hi : ((v < lo + st) ? lo : v - st);
        else e = up ? ((v + st >= hi) ? hi : v + st) : ((v <= lo + st) ? lo : v - st);
        if (sel != 3'h0 || seen) chk(channel_code[11:0], e);
        if (channel_code[11:0] == hi[11:0]) up = 1'b0;
        if (channel_code[11:0] == lo[11:0]) up = 1'b1;
        if (seen) chk(gap, per + 1);
        {v, gap, seen} = {1'b0, channel_code[11:0], 32'd0, 1'b1};
      end
    end
    chk(seen, 1'b1);
  endtask
  task automatic t_sine;
    int idx;
    for (int p = 0; p < 4; p++) begin
      {write_channel, write_waveform_select, write_sine_phase} = {2'h1, 3'h4, p[1:0]};
      {write_step_period, write_run} = {16'h0000, 1'b0};
      wr();
      // Idle code is registered twice before it shows
      repeat (2) @(negedge clock);
      idx = 6 * p;
      chk(channel_code[23:12], sine_pt(idx));
      write_run = 1'b1;
      wr();
      repeat (30) begin
        @(negedge clock);
        if (channel_code[23:12] !== sine_pt(idx)) begin
          idx = (idx + 1) % 24;
          chk(channel_code[23:12], sine_pt(idx));
        end
      end
    end
  endtask
  task automatic t_power;
    for (int c = 0; c < 4; c++) begin
      set_ch(2'h2, c[1:0], c[0]);
      wr();
      chk({vout_pulldown_10k[2], vout_pulldown_100k[2], voltage_out_enable[2],
        current_out_enable[2]}, {c == 1, c == 2, c == 0, !c[0]});
    end
    set_ch(2'h0, 2'h0, 1'b0);
    write_gpio_sleep_map = 1'b1;
    wr();
    {gpio_is_sleep, gpio_in} = 2'b10;
    @(negedge clock);
    chk({voltage_out_enable[0], current_out_enable[0]}, 2'b00);
    gpio_in = 1'b1;
    @(negedge clock);
    chk({voltage_out_enable[0], current_out_enable[0]}, 2'b11);
    {gpio_is_sleep, write_gpio_sleep_map} = 2'b00;
  endtask
  task automatic t_lock;
    write_reference_enable = 1'b1;
    com(1'b1);
    chk({write_lock, lock_bypassed, reference_enable}, 3'b101);
    set_ch(2'h2, 2'h0, 1'b0);
    @(negedge clock) write_strobe = 1'b1;
    #1 chk(write_rejected, 1'b1);
    @(negedge clock) write_strobe = 1'b0;
    chk({voltage_out_enable[2], current_out_enable[2]}, 2'b00);
    act(4'h0, 4'h5);
    chk(lock_bypassed, 1'b1);
    wr();
    chk({voltage_out_enable[2], current_out_enable[2]}, 2'b11);
    com(1'b0);
    act(4'ha, 4'h0);
    chk(booting, 1'b1);
    wait_ready();
    pwr_default();
  endtask
  task automatic t_store;
    bad_user = 1'b1;
    act(4'ha, 4'h0);
    wait_ready();
    chk({user_store_check_fail, factory_store_check_fail}, 2'b10);
    chk({voltage_out_enable, current_out_enable}, 12'h000);
    set_ch(2'h3, 2'h0, 1'b0);
    wr();
    chk({voltage_out_enable[3], current_out_enable[3]}, 2'b11);
    {bad_factory, gpio_is_reset, gpio_in} = 3'b110; // Low pulse, pin mode kept
    repeat (3) @(negedge clock);
    chk(booting, 1'b1);
    gpio_in = 1'b1;
    wait_ready();
    chk({user_store_check_fail, factory_store_check_fail}, 2'b11);
    {bad_user, bad_factory, gpio_in} = 3'b000;
    repeat (2) @(negedge clock);
    chk(booting, 1'b1);
    wait_ready();
    gpio_in = 1'b1;
    repeat (4) @(negedge clock);
    chk(host_ready, 1'b1);
    chk({user_store_check_fail, factory_store_check_fail}, 2'b00);
    pwr_default();
    gpio_is_reset = 1'b0;
  endtask

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Whole run needs well under 5000 cycles
  initial begin
    #(40 * 20000);
    bad_count++;
    end_sim();
  end
  initial begin
    t_boot();
    t_saw(3'h1, 13'd0, 13'd3, 13'd1, 0);
    t_saw(3'h1, 13'd2, 13'd8, 13'd4, 2);
    t_saw(3'h2, 13'd4, 13'd20, 13'd3, 1);
    t_saw(3'h0, 13'd1, 13'd9, 13'd2, 0);
    t_sine();
    t_power();
    t_lock();
    t_store();
    end_sim();
  end
endmodule // test_dac_wavegen_reset_powerdown_ctrl
`default_nettype wire
